// File: src/dce_map.vh
`ifndef DCE_MAP_VH
`define DCE_MAP_VH

// ==========================================================
// descriptor word index within one 8-word (32-byte) slot
`define DCE_W_SRC      3'h0
`define DCE_W_SOFF     3'h1
`define DCE_W_SLAST    3'h2
`define DCE_W_DST      3'h3
`define DCE_W_DOFF     3'h4
`define DCE_W_DLAST    3'h5
`define DCE_W_MINOR    3'h6
`define DCE_W_CTRL     3'h7
`define DCE_WORDS      8

// ==========================================================
// control word fields
`define DCE_CUR_LSB    0
`define DCE_CUR_MSB    13
`define DCE_SG_BIT     14
`define DCE_START_LSB  16
`define DCE_START_MSB  29
`define DCE_IHALF_BIT  30
`define DCE_IMAJ_BIT   31
`define DCE_CNT_W      14

// ==========================================================
// access size and bandwidth stall
`define DCE_XFER_BYTES 32'h0000_0004
`define DCE_BW_SHORT   2'h2
`define DCE_BW_LONG    2'h3
`define DCE_STALL_4    4'h4
`define DCE_STALL_8    4'h8

// ==========================================================
// reset values
`define DCE_ZERO32     32'h0000_0000

`endif

// File: src/dce_fifo.v
`timescale 1ns/1ps
module dce_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             reset,
  // fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_reg;
  reg [AW-1:0]    rdPtr_reg;
  reg [AW:0]      count_reg;
  wire            doPush;
  wire            doPop;

  assign inReady  = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr_reg];
  assign doPush   = inValid & inReady;
  assign doPop    = outReady & outValid;

  always @(posedge core_clk) begin
    if (reset) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        mem[wrPtr_reg] <= inData;
        wrPtr_reg      <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (doPop)
        rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      if (doPush && !doPop)
        count_reg <= count_reg + 1'b1;
      else if (doPop && !doPush)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // dce_fifo

// File: src/dce_engine.v
`timescale 1ns/1ps
`include "dce_map.vh"
module dce_engine #(
  parameter CHANNELS = 16,
  parameter CH_W     = 4,
  parameter FIFO_D   = 4,
  parameter FIFO_AW  = 2
) (
  // clock and reset
  input  wire                     core_clk,
  input  wire                     reset,
  // requests and channel configuration
  input  wire [CHANNELS-1:0]      chRequest,
  input  wire                     roundRobin,
  input  wire [CHANNELS*4-1:0]    chPriority,
  input  wire [1:0]               bwSelect,
  input  wire [CHANNELS*5-1:0]    srcModulo,
  input  wire [CHANNELS*5-1:0]    dstModulo,
  input  wire [CHANNELS-1:0]      linkMinorEn,
  input  wire [CHANNELS*CH_W-1:0] linkMinorCh,
  input  wire [CHANNELS-1:0]      linkMajorEn,
  input  wire [CHANNELS*CH_W-1:0] linkMajorCh,
  // software descriptor write
  input  wire                     descWrEn,
  input  wire [CH_W-1:0]          descWrCh,
  input  wire [2:0]               descWrIdx,
  input  wire [31:0]              descWrData,
  output reg                      descBusy_reg,
  // memory master
  output reg                      memRdReq_reg,
  output reg                      memWrReq_reg,
  output reg  [31:0]              memAddr_reg,
  output reg  [31:0]              memWrData_reg,
  input  wire                     memAck,
  input  wire [31:0]              memRdData,
  // status
  output reg                      busy_reg,
  output reg  [CH_W-1:0]          activeCh_reg,
  output reg  [CHANNELS-1:0]      majorIrq_reg,
  output reg  [CHANNELS-1:0]      halfIrq_reg
);
  // ==========================================================
  // states
  localparam ST_IDLE = 3'h0;
  localparam ST_LOAD = 3'h1;
  localparam ST_XFER = 3'h2;
  localparam ST_END  = 3'h3;
  localparam ST_SG   = 3'h4;

  reg [31:0]         desc [0:CHANNELS*`DCE_WORDS-1];
  reg [2:0]          st_reg;
  reg [CH_W-1:0]     ch_reg;
  reg [CH_W-1:0]     rrLast_reg;
  reg [CHANNELS-1:0] pend_reg;
  reg [31:0]         src_reg;
  reg [31:0]         dst_reg;
  reg [31:0]         rdLeft_reg;
  reg [31:0]         wrLeft_reg;
  reg [3:0]          stall_reg;
  reg [2:0]          sgIdx_reg;
  reg [31:0]         sgPtr_reg;

  // ==========================================================
  // descriptor field taps
  function [CH_W+2:0] slot;
    input [CH_W-1:0] c;
    input [2:0]      w;
    slot = {c, w};
  endfunction

  function [31:0] modStep;
    input [31:0] a;
    input [31:0] off;
    input [4:0]  m;
    reg   [31:0] mask;
    reg   [31:0] sum;
    begin
      mask    = (m == 5'h00) ? 32'hFFFF_FFFF : ((32'h0000_0001 << m) - 32'h0000_0001);
      sum     = a + off;
      modStep = (a & ~mask) | (sum & mask);
    end
  endfunction

  wire [31:0] ctrlW   = desc[slot(ch_reg, `DCE_W_CTRL)];
  wire [13:0] curCnt  = ctrlW[`DCE_CUR_MSB:`DCE_CUR_LSB];
  wire [13:0] startCt = ctrlW[`DCE_START_MSB:`DCE_START_LSB];
  wire [13:0] curDec  = curCnt - 14'h0001;
  wire        sgOn    = ctrlW[`DCE_SG_BIT];
  wire [4:0]  sMod    = srcModulo[ch_reg*5 +: 5];
  wire [4:0]  dMod    = dstModulo[ch_reg*5 +: 5];
  wire [3:0]  stallLd = (bwSelect == `DCE_BW_LONG)  ? `DCE_STALL_8 :
                        (bwSelect == `DCE_BW_SHORT) ? `DCE_STALL_4 : 4'h0;

  // ==========================================================
  // channel arbitration
  reg            grantValid;
  reg [CH_W-1:0] grantCh;
  reg [3:0]      bestPri;
  reg [CH_W:0]   rrIdx;
  integer        i;

  always @* begin
    grantValid = 1'b0;
    grantCh    = {CH_W{1'b0}};
    bestPri    = 4'h0;
    rrIdx      = {(CH_W+1){1'b0}};
    for (i = 0; i < CHANNELS; i = i + 1) begin
      if (roundRobin) begin
        rrIdx = {1'b0, rrLast_reg} + 1'b1 + i[CH_W:0];
        if (rrIdx >= CHANNELS[CH_W:0])
          rrIdx = rrIdx - CHANNELS[CH_W:0];
        if (pend_reg[rrIdx[CH_W-1:0]] && !grantValid) begin
          grantValid = 1'b1;
          grantCh    = rrIdx[CH_W-1:0];
        end
      end else if (pend_reg[i] && (!grantValid || chPriority[i*4 +: 4] > bestPri)) begin
        grantValid = 1'b1;
        grantCh    = i[CH_W-1:0];
        bestPri    = chPriority[i*4 +: 4];
      end
    end
  end

  // ==========================================================
  // data fifo
  wire        opBusy   = memRdReq_reg | memWrReq_reg;
  wire        rdDone   = memRdReq_reg & memAck & (st_reg == ST_XFER);
  wire        fifoInRdy;
  wire        fifoOutVal;
  wire [31:0] fifoOut;
  wire        idleSlot = (st_reg == ST_XFER) && !opBusy && (stall_reg == 4'h0);
  wire        issueRd  = idleSlot && (rdLeft_reg != `DCE_ZERO32) && fifoInRdy;
  wire        issueWr  = idleSlot && !issueRd && fifoOutVal && (wrLeft_reg != `DCE_ZERO32);

  dce_fifo #(
    .WIDTH    (32),
    .DEPTH    (FIFO_D),
    .AW       (FIFO_AW)
  ) dataFifo (
    .core_clk (core_clk),
    .reset    (reset),
    .inValid  (rdDone),
    .inReady  (fifoInRdy),
    .inData   (memRdData),
    .outValid (fifoOutVal),
    .outReady (issueWr),
    .outData  (fifoOut)
  );

  // ==========================================================
  // request pending and link set
  reg [CHANNELS-1:0] linkSet;
  reg [CHANNELS-1:0] grantClr;

  always @* begin
    linkSet  = {CHANNELS{1'b0}};
    grantClr = {CHANNELS{1'b0}};
    if (st_reg == ST_IDLE && grantValid)
      grantClr[grantCh] = 1'b1;
    if (st_reg == ST_END) begin
      if (linkMinorEn[ch_reg])
        linkSet[linkMinorCh[ch_reg*CH_W +: CH_W]] = 1'b1;
      if (linkMajorEn[ch_reg] && curDec == 14'h0000)
        linkSet[linkMajorCh[ch_reg*CH_W +: CH_W]] = 1'b1;
    end
  end

  // ==========================================================
  // engine
  always @(posedge core_clk) begin
    if (reset) begin
      st_reg        <= ST_IDLE;
      ch_reg        <= {CH_W{1'b0}};
      rrLast_reg    <= {CH_W{1'b0}};
      pend_reg      <= {CHANNELS{1'b0}};
      src_reg       <= `DCE_ZERO32;
      dst_reg       <= `DCE_ZERO32;
      rdLeft_reg    <= `DCE_ZERO32;
      wrLeft_reg    <= `DCE_ZERO32;
      stall_reg     <= 4'h0;
      sgIdx_reg     <= 3'h0;
      sgPtr_reg     <= `DCE_ZERO32;
      memRdReq_reg  <= 1'b0;
      memWrReq_reg  <= 1'b0;
      memAddr_reg   <= `DCE_ZERO32;
      memWrData_reg <= `DCE_ZERO32;
      busy_reg      <= 1'b0;
      activeCh_reg  <= {CH_W{1'b0}};
      majorIrq_reg  <= {CHANNELS{1'b0}};
      halfIrq_reg   <= {CHANNELS{1'b0}};
      descBusy_reg  <= 1'b0;
    end else begin
      // a new request in the grant cycle survives the clear
      pend_reg     <= (pend_reg & ~grantClr) | chRequest | linkSet;
      majorIrq_reg <= {CHANNELS{1'b0}};
      halfIrq_reg  <= {CHANNELS{1'b0}};
      busy_reg     <= (st_reg != ST_IDLE) || grantValid;
      descBusy_reg <= 1'b0;
      // software writes land only while the engine leaves the array alone
      if (descWrEn && st_reg != ST_END && st_reg != ST_SG)
        desc[slot(descWrCh, descWrIdx)] <= descWrData;
      case (st_reg)
        ST_IDLE: begin
          if (grantValid) begin
            ch_reg       <= grantCh;
            rrLast_reg   <= grantCh;
            activeCh_reg <= grantCh;
            st_reg       <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          src_reg    <= desc[slot(ch_reg, `DCE_W_SRC)];
          dst_reg    <= desc[slot(ch_reg, `DCE_W_DST)];
          rdLeft_reg <= desc[slot(ch_reg, `DCE_W_MINOR)];
          wrLeft_reg <= desc[slot(ch_reg, `DCE_W_MINOR)];
          st_reg     <= ST_XFER;
        end
        ST_XFER: begin
          if (opBusy) begin
            if (memAck) begin
              memRdReq_reg <= 1'b0;
              memWrReq_reg <= 1'b0;
              stall_reg    <= stallLd;
              if (memRdReq_reg) begin
                src_reg    <= modStep(src_reg, desc[slot(ch_reg, `DCE_W_SOFF)], sMod);
                rdLeft_reg <= rdLeft_reg - `DCE_XFER_BYTES;
              end else begin
                dst_reg    <= modStep(dst_reg, desc[slot(ch_reg, `DCE_W_DOFF)], dMod);
                wrLeft_reg <= wrLeft_reg - `DCE_XFER_BYTES;
              end
            end
          end else if (stall_reg != 4'h0) begin
            stall_reg <= stall_reg - 4'h1;
          end else if (issueRd) begin
            memRdReq_reg <= 1'b1;
            memAddr_reg  <= src_reg;
          end else if (issueWr) begin
            memWrReq_reg  <= 1'b1;
            memAddr_reg   <= dst_reg;
            memWrData_reg <= fifoOut;
          end else if (rdLeft_reg == `DCE_ZERO32 && wrLeft_reg == `DCE_ZERO32) begin
            st_reg       <= ST_END;
            descBusy_reg <= 1'b1;
          end
        end
        ST_END: begin
          if (curDec == 14'h0000) begin
            desc[slot(ch_reg, `DCE_W_SRC)] <= src_reg + desc[slot(ch_reg, `DCE_W_SLAST)];
            // with chaining the last word is the next-descriptor pointer
            if (!sgOn)
              desc[slot(ch_reg, `DCE_W_DST)] <= dst_reg + desc[slot(ch_reg, `DCE_W_DLAST)];
            else
              desc[slot(ch_reg, `DCE_W_DST)] <= dst_reg;
            desc[slot(ch_reg, `DCE_W_CTRL)] <= {ctrlW[31:14], startCt};
            majorIrq_reg[ch_reg]            <= ctrlW[`DCE_IMAJ_BIT];
          end else begin
            desc[slot(ch_reg, `DCE_W_SRC)]  <= src_reg;
            desc[slot(ch_reg, `DCE_W_DST)]  <= dst_reg;
            desc[slot(ch_reg, `DCE_W_CTRL)] <= {ctrlW[31:14], curDec};
          end
          if (ctrlW[`DCE_IHALF_BIT] && curDec == {1'b0, startCt[13:1]})
            halfIrq_reg[ch_reg] <= 1'b1;
          if (curDec == 14'h0000 && sgOn) begin
            sgPtr_reg    <= desc[slot(ch_reg, `DCE_W_DLAST)];
            sgIdx_reg    <= 3'h0;
            st_reg       <= ST_SG;
            descBusy_reg <= 1'b1;
          end else begin
            st_reg <= ST_IDLE;
          end
        end
        ST_SG: begin
          descBusy_reg <= 1'b1;
          if (memRdReq_reg) begin
            if (memAck) begin
              memRdReq_reg                    <= 1'b0;
              stall_reg                       <= stallLd;
              desc[slot(ch_reg, sgIdx_reg)]   <= memRdData;
              sgIdx_reg                       <= sgIdx_reg + 3'h1;
              if (sgIdx_reg == 3'h7) begin
                st_reg       <= ST_IDLE;
                descBusy_reg <= 1'b0;
              end
            end
          end else if (stall_reg != 4'h0) begin
            // descriptor fetches obey the same bus stall as data moves
            stall_reg <= stall_reg - 4'h1;
          end else begin
            memRdReq_reg <= 1'b1;
            memAddr_reg  <= sgPtr_reg + {27'h000_0000, sgIdx_reg, 2'h0};
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // dce_engine

// File: dv/dce_engine_props.sv
`timescale 1ns/1ps
module dce_engine_props #(
  parameter CHANNELS = 16
) (
  input wire logic                core_clk,
  input wire logic                reset,
  input wire logic [CHANNELS-1:0] chRequest,
  input wire logic [1:0]          bwSelect,
  input wire logic                descBusy_reg,
  input wire logic                memRdReq_reg,
  input wire logic                memWrReq_reg,
  input wire logic [31:0]         memAddr_reg,
  input wire logic [31:0]         memWrData_reg,
  input wire logic                memAck,
  input wire logic                busy_reg,
  input wire logic [CHANNELS-1:0] majorIrq_reg,
  input wire logic [CHANNELS-1:0] halfIrq_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire anyReq = memRdReq_reg || memWrReq_reg;
  // ==========
  // memory handshake
  property p_rd_hold;
    memRdReq_reg && !memAck |=> memRdReq_reg && $stable(memAddr_reg);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request left before ack");
  property p_wr_hold;
    memWrReq_reg && !memAck |=> memWrReq_reg && $stable(memAddr_reg) && $stable(memWrData_reg);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request left before ack");
  property p_excl;
    !(memRdReq_reg && memWrReq_reg);
  endproperty
  a_excl: assert property (p_excl) else $error("read and write requested together");
  // ==========
  // start only on a request
  property p_req_busy;
    anyReq |-> busy_reg;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("memory access while idle");
  property p_start;
    $rose(busy_reg) |-> ($past(chRequest, 1) != 0) || ($past(chRequest, 2) != 0) || ($past(chRequest, 3) != 0);
  endproperty
  a_start: assert property (p_start) else $error("engine woke without a request");
  // ==========
  // bandwidth stall
  property p_stall4;
    anyReq && memAck && bwSelect == 2'h2 |=> !anyReq [*4];
  endproperty
  a_stall4: assert property (p_stall4) else $error("short stall not kept");
  property p_stall8;
    anyReq && memAck && bwSelect == 2'h3 |=> !anyReq [*8];
  endproperty
  a_stall8: assert property (p_stall8) else $error("long stall not kept");
  // ==========
  // interrupts
  property p_irq_pulse;
    (|majorIrq_reg) || (|halfIrq_reg) |=> !(|majorIrq_reg) && !(|halfIrq_reg) && $onehot0($past(majorIrq_reg));
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
  property p_irq_end;
    |majorIrq_reg |-> $past(descBusy_reg);
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("major interrupt outside loop end");
endmodule // dce_engine_props

bind dce_engine dce_engine_props #(.CHANNELS(CHANNELS)) i_props (.*);

// File: dv/dce_mem_model.sv
`timescale 1ns/1ps
module dce_mem_model (
  input  wire logic        core_clk,
  input  wire logic        memRdReq_reg,
  input  wire logic        memWrReq_reg,
  input  wire logic [31:0] memAddr_reg,
  input  wire logic [31:0] memWrData_reg,
  output logic             memAck,
  output logic [31:0]      memRdData
);
  logic [31:0] mem [0:1023];
  wire  [31:0] word = mem[memAddr_reg[11:2]];
  // no stale word outside the ack cycle
  assign memRdData = memAck ? word : ~word;
  initial memAck = 1'b0;
  // random wait states, zero to several cycles
  always @(posedge core_clk) begin
    if ((memRdReq_reg || memWrReq_reg) && !memAck && $urandom_range(2) == 0) begin
      memAck <= 1'b1;
      if (memWrReq_reg) mem[memAddr_reg[11:2]] <= memWrData_reg;
    end else memAck <= 1'b0;
  end
endmodule // dce_mem_model

// File: dv/test_dce_engine.sv
`timescale 1ns/1ps
module test_dce_engine;
  localparam logic [31:0] Z = 32'h0000_0000, W4 = 32'h0000_0004, C1 = 32'h0001_0001;
  logic core_clk = 1'b0, reset = 1'b1;
  logic [15:0] chRequest, linkMinorEn, linkMajorEn, majSeen, halfSeen;
  logic [63:0] chPriority, linkMinorCh, linkMajorCh;
  logic [79:0] srcModulo, dstModulo;
  logic [1:0] bwSelect;
  logic [3:0] descWrCh, firstCh, activeCh_reg;
  logic [2:0] descWrIdx;
  logic [31:0] descWrData, memAddr_reg, memWrData_reg, memRdData;
  logic [255:0] nd;
  logic roundRobin, descWrEn, descBusy_reg, memRdReq_reg, memWrReq_reg, memAck, busy_reg, grab, rdPrev;
  logic [15:0] majorIrq_reg, halfIrq_reg;
  int mismatches = 0, cmp_count = 0, cyc = 0;

  always #2.5 core_clk = ~core_clk;
  dce_engine i_dut (.*);
  dce_mem_model i_mem (.*);

  // ==========
  // checking
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic cm(input string nm, input logic [11:0] d, s);
    chk(nm, i_mem.mem[d[11:2]], i_mem.mem[s[11:2]]);
  endtask
  task automatic results;
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    // outputs are unknown until the first reset edge
    majSeen <= reset ? '0 : majSeen | majorIrq_reg;
    halfSeen <= reset ? '0 : halfSeen | halfIrq_reg;
    rdPrev <= memRdReq_reg;
    if (grab && memRdReq_reg && !rdPrev) begin
      firstCh <= activeCh_reg;
      grab <= 1'b0;
    end
    if (cyc == 40000) begin
      mismatches++;
      results();
    end
  end

  // ==========
  // drivers
  task automatic desc(input logic [3:0] c, input logic [255:0] v);
    for (int i = 0; i < 8; i++) begin
      descWrEn = 1'b1;
      descWrCh = c;
      descWrIdx = i[2:0];
      descWrData = v[i*32 +: 32];
      @(posedge core_clk);
      #1;
    end
    descWrEn = 1'b0;
  endtask
  // one pulse per minor loop; waits out links and pending grants too
  task automatic go(input logic [15:0] m);
    chRequest = m;
    @(posedge core_clk);
    #1;
    chRequest = '0;
    repeat (3) @(posedge core_clk);
    while (busy_reg !== 1'b0) @(posedge core_clk);
    #1;
  endtask
  task automatic fill(input logic [11:0] a, input int n);
    for (int i = 0; i < n; i++) i_mem.mem[a[11:2] + i] = $urandom;
  endtask

  // ==========
  // scenarios
  initial begin
    void'($urandom(38574));
    {chRequest, roundRobin, chPriority, bwSelect, srcModulo, dstModulo} = '0;
    {linkMinorEn, linkMinorCh, linkMajorEn, linkMajorCh, descWrEn, descWrCh, descWrIdx, descWrData} = '0;
    {majSeen, halfSeen, grab, rdPrev, firstCh} = '0;
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    bwSelect = 2'h2;
    fill(12'h100, 4);
    desc(4'h0, {32'hC002_0002, 32'h0000_0008, 32'hFFFF_FFF0, W4, 32'h0000_0200, 32'hFFFF_FFF0, W4, 32'h0000_0100});
    go(16'h0001);
    chk("half irq", halfSeen[0], 1'b1);
    chk("early major irq", majSeen[0], 1'b0);
    go(16'h0001);
    chk("major irq", majSeen[0], 1'b1);
    for (int i = 0; i < 4; i++) cm("copy", 12'h200 + 4*i, 12'h100 + 4*i);
    fill(12'h100, 2);
    go(16'h0001);
    for (int i = 0; i < 2; i++) cm("rewind", 12'h200 + 4*i, 12'h100 + 4*i);
    // descending source, long stall
    bwSelect = 2'h3;
    fill(12'h110, 4);
    desc(4'h1, {C1, 32'h0000_0010, Z, W4, 32'h0000_0220, Z, 32'hFFFF_FFFC, 32'h0000_011C});
    go(16'h0002);
    for (int i = 0; i < 4; i++) cm("down", 12'h220 + 4*i, 12'h11C - 4*i);
    bwSelect = 2'h0;
    srcModulo[14:10] = 5'h03;
    fill(12'h300, 2);
    desc(4'h2, {C1, 32'h0000_0010, Z, W4, 32'h0000_0400, Z, W4, 32'h0000_0300});
    go(16'h0004);
    for (int i = 0; i < 4; i++) cm("wrap", 12'h400 + 4*i, 12'h300 + 4*(i%2));
    linkMinorEn[3] = 1'b1;
    linkMinorCh[15:12] = 4'h4;
    linkMajorEn[4] = 1'b1;
    linkMajorCh[19:16] = 4'h9;
    fill(12'h500, 4);
    desc(4'h3, {C1, W4, Z, W4, 32'h0000_0540, Z, W4, 32'h0000_0500});
    desc(4'h4, {C1, W4, Z, W4, 32'h0000_0544, Z, W4, 32'h0000_0504});
    desc(4'h9, {C1, W4, Z, W4, 32'h0000_0558, Z, W4, 32'h0000_0500});
    go(16'h0008);
    cm("linked", 12'h544, 12'h504);
    cm("major linked", 12'h558, 12'h500);
    // next descriptor sits in memory at 0x600
    nd = {32'h8001_0001, W4, Z, W4, 32'h0000_054C, Z, W4, 32'h0000_050C};
    for (int i = 0; i < 8; i++) i_mem.mem[10'h180 + i] = nd[i*32 +: 32];
    desc(4'h5, {32'h0001_4001, W4, 32'h0000_0600, W4, 32'h0000_0548, Z, W4, 32'h0000_0508});
    go(16'h0020);
    cm("first", 12'h548, 12'h508);
    go(16'h0020);
    cm("chained", 12'h54C, 12'h50C);
    chk("chained irq", majSeen[5], 1'b1);
    chPriority[27:24] = 4'h1;
    chPriority[31:28] = 4'hF;
    desc(4'h6, {C1, W4, Z, W4, 32'h0000_0550, Z, Z, 32'h0000_0510});
    desc(4'h7, {C1, W4, Z, W4, 32'h0000_0554, Z, Z, 32'h0000_0514});
    grab = 1'b1;
    go(16'h00C0);
    chk("fixed winner", firstCh, 4'h7);
    go(16'h0080);
    roundRobin = 1'b1;
    grab = 1'b1;
    go(16'h00C0);
    chk("rotating winner", firstCh, 4'h6);
    results();
  end
endmodule // test_dce_engine
